//--- hw/plpc_pkg.sv
// Purpose: Shared constants and carriers for the pulse, lock and phase-order register bank
// Assumes: 24-bit registers addressed by page-local index over the serial port
// Notes:   Offsets are page-local register indices

package plpc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [5:0]  OFS_CRIT_CHECKSUM = 6'h01;
   localparam logic [5:0]  OFS_SOURCE_SELECT = 6'h09;
   localparam logic [5:0]  OFS_FULL_SCALE    = 6'h1C;
   localparam logic [5:0]  OFS_WRITE_PROTECT = 6'h22;
   localparam logic [5:0]  OFS_PHASE_ORDER   = 6'h23;
   localparam logic [5:0]  OFS_INT_FLAGS     = 6'h17;
   localparam logic [5:0]  OFS_CHIP_FLAGS_1  = 6'h18;
   localparam logic [5:0]  OFS_CHIP_FLAGS_2  = 6'h19;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [23:0] RST_FULL_SCALE    = 24'h800000;
   localparam logic [23:0] RST_SOURCE_SELECT = 24'h000000;
   localparam logic [23:0] RST_WRITE_PROTECT = 24'h000000;
   localparam logic [23:0] RST_PHASE_ORDER   = 24'h000000;
   localparam logic [23:0] RST_CHECKSUM      = 24'h000000;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int          POS_ENGINE_LOCK   = 8;
   localparam int          POS_HOST_LOCK     = 0;
   localparam int          POS_PS_VALID      = 23;
   localparam int          POS_PS_COUNT      = 16;
   localparam int          POS_PS_DIR        = 5;
   localparam int          POS_PS_CODE       = 0;
   localparam logic [4:0]  LOCK_CODE         = 5'h16;
   localparam logic [4:0]  UNLOCK_CODE       = 5'h09;
   localparam logic [4:0]  PS_START_CODE     = 5'h16;
   localparam logic [3:0]  SRC_LAST_USED     = 4'h8;
   localparam logic [23:0] MASK_SOURCE       = 24'h00FFFF;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          WORD_RATE_HZ      = 4000;
   localparam int          MAX_PULSE_HZ      = 2000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PS_IDLE  = 2'b00,
      PS_ARMED = 2'b01,
      PS_COUNT = 2'b11
   } plpc_ps_state_t;

   typedef struct packed {
      logic        wr;
      logic [5:0]  addr;
      logic [23:0] wdata;
   } plpc_host_req_t;

   typedef struct packed {
      logic        engine_lock;
      logic        host_lock;
   } plpc_lock_t;

   typedef struct packed {
      logic           valid;
      logic [6:0]     count;
      logic           dir;
      logic [6:0]     run_cnt;
      logic           prev_pos;
      plpc_ps_state_t state;
   } plpc_ps_t;

endpackage : plpc_pkg

//--- hw/plpc_lock_decode.sv
// Purpose: Decodes one lock field write into the next protection state
// Assumes: Called on a host write to the write protection register
// Notes:   Pure combinational

module plpc_lock_decode (
   input  wire logic       wr_in,
   input  wire logic [4:0] field_in,
   input  wire logic       cur_in,
   output logic            nxt_out
);

   always_comb begin
      nxt_out = cur_in;
      if (wr_in) begin
         // R4: lock and unlock codes
         if (field_in == plpc_pkg::LOCK_CODE) begin
            nxt_out = 1'b1;
         end else if (field_in == plpc_pkg::UNLOCK_CODE) begin
            nxt_out = 1'b0;
         end
         // R11: other codes hold
      end
   end

endmodule : plpc_lock_decode

//--- hw/plpc_regs.sv
// Purpose: Pulse rate, pulse source, write protect, phase order and checksum registers
// Assumes: Host requests and output-word-rate strobe synchronous to REF_CLK_IN
// Notes:   Checksum value is supplied by the checksum engine outside
//          An engine write to the rate beats a host write in the same cycle
//          Status indices stay writable under host lock but hold nothing here
//          Phase order register index is a local choice
//          Sample count saturates at 127 when no stopping edge arrives

// ----------------------------------------------------------------
// Register bank
// ----------------------------------------------------------------
// Summary of operation
// R1: Pulse rate is a 24-bit signed fraction, reset value 0x800000.
// R2: Pulse rate sets full-scale pulse frequency, 2 kHz at 4 kHz word rate.
// R3: Four 4-bit source selectors route power sources to the pulse generators.
// R4: Engine lock code 0x16 blocks engine writes; 0x09 releases.
// R5: Host lock code 0x16 blocks host writes except lock and status registers.
// R6: Valid flag bit 23 is 1 only when the count holds a valid result.
// R7: Count captures word-rate samples from start to the chosen zero crossing.
// R8: Direction bit 0 stops at rising crossing, 1 at falling crossing.
// R9: Detection starts only when code 10110 is written to the enable field.
// R10: Checksum register shows a 24-bit checksum, reset zero.
// R11: Other lock field values leave protection unchanged.
// R12: Starting detection clears valid until the count is captured.
module plpc_regs (
   input  wire logic          REF_CLK_IN,
   input  wire logic          RST_IN,
   input  wire logic          CE_IN,
   input  wire logic          HOST_WR_IN,
   input  wire logic          HOST_RD_IN,
   input  wire logic [5:0]    HOST_ADDR_IN,
   input  wire logic [23:0]   HOST_WDATA_IN,
   input  wire logic          ENGINE_WR_IN,
   input  wire logic [5:0]    ENGINE_ADDR_IN,
   input  wire logic [23:0]   ENGINE_WDATA_IN,
   input  wire logic          WORD_RATE_STROBE_IN,
   input  wire logic          LINE_SIGN_IN,
   input  wire logic [23:0]   CHECKSUM_IN,
   output logic [23:0]        HOST_RDATA_OUT,
   output logic               HOST_RVALID_OUT,
   output logic [23:0]        PULSE_RATE_OUT,
   output logic [15:0]        PULSE_SOURCE_OUT,
   output logic               ENGINE_LOCKED_OUT,
   output logic               HOST_LOCKED_OUT,
   output logic               ENGINE_WR_BLOCKED_OUT
);

   // ----------------------------------------------------------------
   // Local state
   // ----------------------------------------------------------------
   typedef struct packed {
      // Host-visible registers
      logic [23:0]         rate;
      logic [15:0]         src;
      logic [4:0]          eng_field;
      logic [4:0]          host_field;
      plpc_pkg::plpc_lock_t lock;
      plpc_pkg::plpc_ps_t  ps;
      logic [23:0]         chk;
      // Read path and refusal pulse
      logic [23:0]         rdata;
      logic                rvalid;
      logic                eng_blk;
   } plpc_state_t;

   plpc_state_t state_ff;
   plpc_state_t nxt_state;
   logic        nxt_eng_lock;
   logic        nxt_host_lock;
   logic        lock_wr;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] fix_src(input logic [3:0] code);
      // R3: unused codes stored as written
      fix_src = code;
   endfunction : fix_src

   // R8: stop edge test
   function automatic logic stop_edge(input logic dir,
                                      input logic prev_pos,
                                      input logic now_pos);
      if (dir) begin
         stop_edge = prev_pos & ~now_pos;
      end else begin
         stop_edge = ~prev_pos & now_pos;
      end
   endfunction : stop_edge

   // R7: saturating sample count
   function automatic logic [6:0] next_run_cnt(input logic [6:0] cnt);
      if (cnt == 7'h7F) begin
         next_run_cnt = cnt;
      end else begin
         next_run_cnt = cnt + 7'h01;
      end
   endfunction : next_run_cnt

   // R9: start pattern check
   function automatic logic is_start_code(input logic [23:0] word);
      is_start_code = (word[plpc_pkg::POS_PS_CODE +: 5] == plpc_pkg::PS_START_CODE);
   endfunction : is_start_code

   // R5: writable under host lock
   function automatic logic host_exempt(input logic [5:0] addr);
      host_exempt = (addr == plpc_pkg::OFS_WRITE_PROTECT) ||
                    (addr == plpc_pkg::OFS_INT_FLAGS) ||
                    (addr == plpc_pkg::OFS_CHIP_FLAGS_1) ||
                    (addr == plpc_pkg::OFS_CHIP_FLAGS_2);
   endfunction : host_exempt

   // Reserved bits and unmapped indices read as zero
   function automatic logic [23:0] read_word(input plpc_state_t s,
                                             input logic [5:0]  addr);
      read_word = 24'h000000;
      unique case (addr)
         plpc_pkg::OFS_CRIT_CHECKSUM: begin
            read_word = s.chk;
         end
         plpc_pkg::OFS_SOURCE_SELECT: begin
            read_word = {8'h00, s.src};
         end
         plpc_pkg::OFS_FULL_SCALE: begin
            read_word = s.rate;
         end
         plpc_pkg::OFS_WRITE_PROTECT: begin
            read_word = {11'h000, s.eng_field, 3'h0, s.host_field};
         end
         plpc_pkg::OFS_PHASE_ORDER: begin
            // R6: valid flag on top bit
            read_word = {s.ps.valid, s.ps.count, 10'h000, s.ps.dir, 5'h00};
         end
         default: begin
            read_word = 24'h000000;
         end
      endcase
   endfunction : read_word

   // Initial contents; all other fields clear
   function automatic plpc_state_t reset_state();
      reset_state          = '0;
      reset_state.rate     = plpc_pkg::RST_FULL_SCALE;
      reset_state.src      = plpc_pkg::RST_SOURCE_SELECT[15:0];
      reset_state.chk      = plpc_pkg::RST_CHECKSUM;
      reset_state.ps.state = plpc_pkg::PS_IDLE;
   endfunction : reset_state

   // ----------------------------------------------------------------
   // Lock field decoders
   // ----------------------------------------------------------------
   // CE gates the strobe so a frozen block ignores lock writes too
   assign lock_wr = CE_IN & HOST_WR_IN & (HOST_ADDR_IN == plpc_pkg::OFS_WRITE_PROTECT);

   plpc_lock_decode u_eng_lock (
      .wr_in    (lock_wr),
      .field_in (HOST_WDATA_IN[plpc_pkg::POS_ENGINE_LOCK +: 5]),
      .cur_in   (state_ff.lock.engine_lock),
      .nxt_out  (nxt_eng_lock)
   );

   plpc_lock_decode u_host_lock (
      .wr_in    (lock_wr),
      .field_in (HOST_WDATA_IN[plpc_pkg::POS_HOST_LOCK +: 5]),
      .cur_in   (state_ff.lock.host_lock),
      .nxt_out  (nxt_host_lock)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic host_ok;
      logic zc;
      logic ps_start;
      host_ok   = 1'b0;
      zc        = 1'b0;
      ps_start  = 1'b0;
      nxt_state = state_ff;
      nxt_state.rvalid  = 1'b0;
      nxt_state.eng_blk = 1'b0;
      // R10: checksum tracks engine result
      nxt_state.chk = CHECKSUM_IN;
      nxt_state.lock.engine_lock = nxt_eng_lock;
      nxt_state.lock.host_lock   = nxt_host_lock;
      if (lock_wr) begin
         nxt_state.eng_field  = HOST_WDATA_IN[plpc_pkg::POS_ENGINE_LOCK +: 5];
         nxt_state.host_field = HOST_WDATA_IN[plpc_pkg::POS_HOST_LOCK +: 5];
      end

      // ----------------------------------------------------------------
      // Host writes
      // ----------------------------------------------------------------
      // R5: host protection gate
      host_ok = HOST_WR_IN & (~state_ff.lock.host_lock | host_exempt(HOST_ADDR_IN));
      if (host_ok) begin
         unique case (HOST_ADDR_IN)
            plpc_pkg::OFS_FULL_SCALE: begin
               // R1: full fraction stored
               nxt_state.rate = HOST_WDATA_IN;
            end
            plpc_pkg::OFS_SOURCE_SELECT: begin
               nxt_state.src = {fix_src(HOST_WDATA_IN[15:12]), fix_src(HOST_WDATA_IN[11:8]),
                                fix_src(HOST_WDATA_IN[7:4]), fix_src(HOST_WDATA_IN[3:0])};
            end
            plpc_pkg::OFS_PHASE_ORDER: begin
               // R8: stop edge select
               nxt_state.ps.dir = HOST_WDATA_IN[plpc_pkg::POS_PS_DIR];
               // R9: start only on code
               if (is_start_code(HOST_WDATA_IN)) begin
                  ps_start             = 1'b1;
                  // R12: valid cleared on start
                  nxt_state.ps.valid   = 1'b0;
                  nxt_state.ps.run_cnt = 7'h00;
                  nxt_state.ps.state   = plpc_pkg::PS_ARMED;
               end
            end
            default: begin
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Engine writes
      // ----------------------------------------------------------------
      // R4: engine writes blocked
      if (ENGINE_WR_IN) begin
         if (state_ff.lock.engine_lock) begin
            nxt_state.eng_blk = 1'b1;
         end else if (ENGINE_ADDR_IN == plpc_pkg::OFS_FULL_SCALE) begin
            nxt_state.rate = ENGINE_WDATA_IN;
         end
      end

      // ----------------------------------------------------------------
      // Phase order detection
      // ----------------------------------------------------------------
      // R7: count word-rate samples
      zc = stop_edge(state_ff.ps.dir, state_ff.ps.prev_pos, LINE_SIGN_IN);
      // Sign history runs while idle, so a fresh start sees a true edge
      if (WORD_RATE_STROBE_IN) begin
         nxt_state.ps.prev_pos = LINE_SIGN_IN;
      end
      // A start beats a strobe in the same cycle; an old capture must not set valid again
      if (WORD_RATE_STROBE_IN && !ps_start) begin
         unique case (state_ff.ps.state)
            plpc_pkg::PS_IDLE: begin
            end
            plpc_pkg::PS_ARMED: begin
               nxt_state.ps.run_cnt = 7'h01;
               nxt_state.ps.state   = plpc_pkg::PS_COUNT;
            end
            plpc_pkg::PS_COUNT: begin
               if (zc) begin
                  // R6: valid on capture
                  nxt_state.ps.count = state_ff.ps.run_cnt;
                  nxt_state.ps.valid = 1'b1;
                  nxt_state.ps.state = plpc_pkg::PS_IDLE;
               end else begin
                  nxt_state.ps.run_cnt = next_run_cnt(state_ff.ps.run_cnt);
               end
            end
            default: begin
               nxt_state.ps.state = plpc_pkg::PS_IDLE;
            end
         endcase
      end

      // ----------------------------------------------------------------
      // Read path
      // ----------------------------------------------------------------
      // Read data is held until the next read
      if (HOST_RD_IN) begin
         nxt_state.rvalid = 1'b1;
         nxt_state.rdata  = read_word(state_ff, HOST_ADDR_IN);
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN) begin
      // Reset wins over a low clock enable; a low enable holds
      // every field, the one-cycle pulses included
      if (RST_IN) begin
         state_ff <= reset_state();
      end else if (CE_IN) begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // R2: rate drives generators
   assign PULSE_RATE_OUT        = state_ff.rate;
   assign PULSE_SOURCE_OUT      = state_ff.src;
   assign ENGINE_LOCKED_OUT     = state_ff.lock.engine_lock;
   assign HOST_LOCKED_OUT       = state_ff.lock.host_lock;
   assign ENGINE_WR_BLOCKED_OUT = state_ff.eng_blk;
   assign HOST_RDATA_OUT        = state_ff.rdata;
   assign HOST_RVALID_OUT       = state_ff.rvalid;

endmodule : plpc_regs

//--- verif/plpc_regs_asserts.sv
// Purpose: Port-level checks for the register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to plpc_regs from tb_top
module plpc_regs_asserts (
   input wire logic        REF_CLK_IN,
   input wire logic        RST_IN,
   input wire logic        CE_IN,
   input wire logic        HOST_WR_IN,
   input wire logic        HOST_RD_IN,
   input wire logic [5:0]  HOST_ADDR_IN,
   input wire logic [23:0] HOST_WDATA_IN,
   input wire logic        ENGINE_WR_IN,
   input wire logic [5:0]  ENGINE_ADDR_IN,
   input wire logic [23:0] CHECKSUM_IN,
   input wire logic [23:0] HOST_RDATA_OUT,
   input wire logic        HOST_RVALID_OUT,
   input wire logic [23:0] PULSE_RATE_OUT,
   input wire logic [15:0] PULSE_SOURCE_OUT,
   input wire logic        ENGINE_LOCKED_OUT,
   input wire logic        HOST_LOCKED_OUT,
   input wire logic        ENGINE_WR_BLOCKED_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Write decodes
   // ----------------------------------------
   logic       w_lock;
   logic       w_rate;
   logic [4:0] ef;
   logic [4:0] hf;
   assign w_lock = CE_IN && HOST_WR_IN && HOST_ADDR_IN == 6'h22;
   // Engine write in the same cycle wins, so leave it out
   assign w_rate = CE_IN && HOST_WR_IN && HOST_ADDR_IN == 6'h1C && !ENGINE_WR_IN;
   assign ef = HOST_WDATA_IN[12:8];
   assign hf = HOST_WDATA_IN[4:0];
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   property p_rst; $fell(RST_IN) |-> PULSE_RATE_OUT == 24'h800000 && !ENGINE_LOCKED_OUT && !HOST_LOCKED_OUT; endproperty
   property p_elk; w_lock && ef == 5'h16 |=> ENGINE_LOCKED_OUT; endproperty
   property p_eul; w_lock && ef == 5'h09 |=> !ENGINE_LOCKED_OUT; endproperty
   property p_ehd; w_lock && ef != 5'h16 && ef != 5'h09 |=> $stable(ENGINE_LOCKED_OUT); endproperty
   property p_hlk; w_lock && hf == 5'h16 |=> HOST_LOCKED_OUT; endproperty
   property p_hhd; w_lock && hf != 5'h16 && hf != 5'h09 |=> $stable(HOST_LOCKED_OUT); endproperty
   property p_hblk; w_rate && HOST_LOCKED_OUT |=> $stable(PULSE_RATE_OUT); endproperty
   property p_rate; w_rate && !HOST_LOCKED_OUT |=> PULSE_RATE_OUT == $past(HOST_WDATA_IN); endproperty
   property p_eblk; CE_IN && ENGINE_WR_IN && ENGINE_ADDR_IN == 6'h1C && ENGINE_LOCKED_OUT && !HOST_WR_IN
      |=> ENGINE_WR_BLOCKED_OUT && $stable(PULSE_RATE_OUT); endproperty
   property p_chk; CE_IN && HOST_RD_IN && HOST_ADDR_IN == 6'h01 && $stable(CHECKSUM_IN) && $past(CE_IN)
      && !$past(RST_IN) |=> HOST_RVALID_OUT && HOST_RDATA_OUT == $past(CHECKSUM_IN); endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   a_elk: assert property (p_elk) else $error("engine lock missed");
   a_eul: assert property (p_eul) else $error("engine unlock missed");
   a_ehd: assert property (p_ehd) else $error("engine lock moved");
   a_hlk: assert property (p_hlk) else $error("host lock missed");
   a_hhd: assert property (p_hhd) else $error("host lock moved");
   a_hblk: assert property (p_hblk) else $error("locked rate written");
   a_rate: assert property (p_rate) else $error("rate not written");
   a_eblk: assert property (p_eblk) else $error("engine write not refused");
   a_chk: assert property (p_chk) else $error("checksum read wrong");
   c_eblk: cover property (ENGINE_WR_BLOCKED_OUT);
   c_hblk: cover property (w_rate && HOST_LOCKED_OUT);
   c_done: cover property (HOST_RVALID_OUT && HOST_RDATA_OUT[23]);
endmodule : plpc_regs_asserts

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Expected values come from the register map
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, ce = 1, hwr = 0, hrd = 0, ewr = 0, wrs = 0, sgn = 0;
   logic [5:0]  haddr = 6'h00, eaddr = 6'h1C;
   logic [23:0] hwd = '0, ewd = '0, chk = '0, rdata, rate, all_m = 24'hFFFFFF;
   logic [15:0] src;
   logic        rvalid, elk, hlk, eblk;
   int          n_errors = 0, tests_run = 0;
   logic [23:0] rv [2] = '{24'h7FFFFF, 24'h800001};
   always #50 clk = ~clk;
   plpc_regs dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .HOST_WR_IN(hwr), .HOST_RD_IN(hrd),
      .HOST_ADDR_IN(haddr), .HOST_WDATA_IN(hwd), .ENGINE_WR_IN(ewr), .ENGINE_ADDR_IN(eaddr),
      .ENGINE_WDATA_IN(ewd), .WORD_RATE_STROBE_IN(wrs), .LINE_SIGN_IN(sgn), .CHECKSUM_IN(chk),
      .HOST_RDATA_OUT(rdata), .HOST_RVALID_OUT(rvalid), .PULSE_RATE_OUT(rate), .PULSE_SOURCE_OUT(src),
      .ENGINE_LOCKED_OUT(elk), .HOST_LOCKED_OUT(hlk), .ENGINE_WR_BLOCKED_OUT(eblk));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Idle edge first, so a strobe is never set twice in one step
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clk) #1 hwr = 1;
      haddr = a;
      hwd = d;
      @(posedge clk) #1 hwr = 0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [23:0] m, input logic [23:0] e);
      @(posedge clk) #1 hrd = 1;
      haddr = a;
      @(posedge clk) #1 hrd = 0;
      check(rvalid === 1'h1 ? rdata & m : 24'hXXXXXX, e);
   endtask : rd
   task automatic eng(input logic [23:0] d);
      @(posedge clk) #1 ewr = 1;
      ewd = d;
      @(posedge clk) #1 ewr = 0;
   endtask : eng
   task automatic ows(input logic s);
      @(posedge clk) #1 wrs = 1;
      sgn = s;
      @(posedge clk) #1 wrs = 0;
   endtask : ows
   task automatic print_verdict;
      if (n_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 0;
      rd(6'h1C, all_m, 24'h800000);
      rd(6'h09, all_m, 24'h000000);
      rd(6'h22, all_m, 24'h000000);
      rd(6'h23, all_m, 24'h000000);
      rd(6'h01, all_m, 24'h000000);
      rd(6'h3F, all_m, 24'h000000);
      chk = 24'hA5C3E1;
      rd(6'h01, all_m, 24'hA5C3E1);
      foreach (rv[i]) begin
         wr(6'h1C, rv[i]);
         rd(6'h1C, all_m, rv[i]);
      end
      for (int c = 0; c < 16; c++) begin
         wr(6'h09, {8'hFF, {4{c[3:0]}}});
         check({8'h00, src}, {8'h00, {4{c[3:0]}}});
         rd(6'h09, all_m, {8'h00, {4{c[3:0]}}});
      end
      eng(24'h123456);
      check(rate, 24'h123456);
      wr(6'h22, 24'h001600);
      check({23'h0, elk}, 24'h000001);
      eng(24'h654321);
      check({23'h0, eblk}, 24'h000001);
      check(rate, 24'h123456);
      wr(6'h22, 24'h001F00);
      check({23'h0, elk}, 24'h000001);
      wr(6'h22, 24'h000900);
      check({23'h0, elk}, 24'h000000);
      wr(6'h22, 24'h000016);
      check({23'h0, hlk}, 24'h000001);
      wr(6'h1C, 24'h000001);
      wr(6'h09, 24'h000000);
      rd(6'h1C, all_m, 24'h123456);
      rd(6'h09, all_m, 24'h00FFFF);
      wr(6'h22, 24'h000015);
      check({23'h0, hlk}, 24'h000001);
      wr(6'h22, 24'h000009);
      wr(6'h1C, 24'h000001);
      check(rate, 24'h000001);
      wr(6'h23, 24'h000016);
      ows(1'h1);
      ows(1'h0);
      rd(6'h23, 24'h800000, 24'h000000);
      ows(1'h1);
      rd(6'h23, 24'hFF0000, 24'h820000);
      wr(6'h23, 24'h000015);
      rd(6'h23, 24'hFF0000, 24'h820000);
      wr(6'h23, 24'h000036);
      rd(6'h23, 24'h800000, 24'h000000);
      ows(1'h0);
      ows(1'h1);
      ows(1'h1);
      ows(1'h0);
      rd(6'h23, 24'hFF0000, 24'h830000);
      ce = 0;
      wr(6'h1C, 24'h0000AA);
      ce = 1;
      check(rate, 24'h000001);
      // Mid-run reset, one edge long
      rst = 1;
      @(posedge clk) #1 rst = 0;
      rd(6'h1C, all_m, 24'h800000);
      rd(6'h23, all_m, 24'h000000);
      print_verdict();
   end
   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
endmodule : tb_top
bind plpc_regs plpc_regs_asserts chk_u (.*);
